// ---- btirq_map.svh ----
// Register map, field positions, reset values and timing counts
// for the button and thermal interrupt logic.
// Assumes an 8-bit register space reached by the host command port.
`ifndef BTIRQ_MAP_SVH
`define BTIRQ_MAP_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define BTIRQ_ADDR_TSTAT   8'h20
`define BTIRQ_ADDR_TMASK   8'h21
`define BTIRQ_ADDR_TSENSE  8'h22
`define BTIRQ_ADDR_BSTAT   8'h24
`define BTIRQ_ADDR_BMASK   8'h25
`define BTIRQ_ADDR_BSENSE  8'h26

// ------------------------------------------------------------------
// Field positions and valid-bit sets
// ------------------------------------------------------------------
`define BTIRQ_THERM_LOW_BIT  0
`define BTIRQ_THERM_HIGH_BIT 2
`define BTIRQ_PUSH_BIT       0
`define BTIRQ_HOLD_BASE_BIT  1
`define BTIRQ_HOLD_NUM       5
`define BTIRQ_THERM_VALID    8'h05
`define BTIRQ_BTN_VALID      8'h3F

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define BTIRQ_STAT_RST   8'h00
`define BTIRQ_SENSE_RST  8'h00
`define BTIRQ_TMASK_RST  8'h05
`define BTIRQ_BMASK_RST  8'h3F

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define BTIRQ_CLK_NS     50
`define BTIRQ_MS_NS      1000000
`define BTIRQ_MS_CYCLES  (`BTIRQ_MS_NS / `BTIRQ_CLK_NS)
`define BTIRQ_HOLD1_S    1
`define BTIRQ_HOLD2_S    2
`define BTIRQ_HOLD3_S    3
`define BTIRQ_HOLD4_S    4
`define BTIRQ_HOLD8_S    8
`define BTIRQ_MS_PER_S   1000

`endif

// ---- btirq_pkg.sv ----
// Types shared by the button and thermal interrupt logic.
// Assumes the constants of btirq_map.svh alongside.
package btirq_pkg;

  // Debounced state of the power button
  typedef enum logic {
    BTIRQ_BTN_UP,
    BTIRQ_BTN_DOWN
  } btirq_btn_t;

  typedef logic [7:0] btirq_byte_t;

endpackage

// ---- btirq_debounce.sv ----
// Debounce filter for the active-low power button input.
// Assumes a one-cycle millisecond tick and an input already synchronous
// to i_core_clk; limits are in milliseconds.
`timescale 1ns/10ps

module btirq_debounce #(
  parameter int LIM_W = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_tick,
  input  wire logic             i_button_n,
  input  wire logic [LIM_W-1:0] i_fall_ms,
  input  wire logic [LIM_W-1:0] i_rise_ms,
  output logic                  o_pressed,
  output logic                  o_press_pulse,
  output logic                  o_release_pulse
);

  btirq_pkg::btirq_btn_t state_reg;
  logic [LIM_W-1:0]      cnt_reg;
  logic                  differ;
  logic [LIM_W-1:0]      limit;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // Raw level disagrees with the filtered state
  assign differ = (state_reg == btirq_pkg::BTIRQ_BTN_UP) ? !i_button_n
                                                         : i_button_n;
  assign limit  = (state_reg == btirq_pkg::BTIRQ_BTN_UP) ? i_fall_ms
                                                         : i_rise_ms;

  // Any bounce back to the stable level restarts the count
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg       <= btirq_pkg::BTIRQ_BTN_UP;
      cnt_reg         <= '0;
      o_press_pulse   <= 1'b0;
      o_release_pulse <= 1'b0;
    end else begin
      o_press_pulse   <= 1'b0;
      o_release_pulse <= 1'b0;
      if (!differ) begin
        cnt_reg <= '0;
      end else if (i_tick) begin
        if (cnt_reg >= limit) begin
          cnt_reg <= '0;
          case (state_reg)
            btirq_pkg::BTIRQ_BTN_UP: begin
              state_reg     <= btirq_pkg::BTIRQ_BTN_DOWN;
              o_press_pulse <= 1'b1;
            end
            btirq_pkg::BTIRQ_BTN_DOWN: begin
              // Only reachable after a press was accepted
              state_reg       <= btirq_pkg::BTIRQ_BTN_UP;
              o_release_pulse <= 1'b1;
            end
            default: begin
              state_reg <= btirq_pkg::BTIRQ_BTN_UP;
            end
          endcase
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

  assign o_pressed = (state_reg == btirq_pkg::BTIRQ_BTN_DOWN);

endmodule

// ---- btirq_top.sv ----
// Interrupt status, mask and sense logic for the power button and the
// two die-temperature thresholds, driving an active-low interrupt pin.
// Assumes comparator levels and the button input synchronous to the
// clock, and a host register port of one access per cycle.
`timescale 1ns/10ps
`include "btirq_map.svh"

module btirq_top #(
  parameter int MS_CYCLES = `BTIRQ_MS_CYCLES,
  parameter int DBNC_W    = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_power_button_n,
  input  wire logic              i_therm_low_level,
  input  wire logic              i_therm_high_level,
  input  wire logic [DBNC_W-1:0] i_dbnc_fall_ms,
  input  wire logic [DBNC_W-1:0] i_dbnc_rise_ms,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  output logic                   o_irq_out_n
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int PRE_W  = $clog2(MS_CYCLES + 1);
  localparam int HOLD_W = 14;
  localparam int NH     = `BTIRQ_HOLD_NUM;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);
  localparam logic [HOLD_W-1:0] HOLD_MS [NH] = '{
    HOLD_W'(`BTIRQ_HOLD1_S * `BTIRQ_MS_PER_S),
    HOLD_W'(`BTIRQ_HOLD2_S * `BTIRQ_MS_PER_S),
    HOLD_W'(`BTIRQ_HOLD3_S * `BTIRQ_MS_PER_S),
    HOLD_W'(`BTIRQ_HOLD4_S * `BTIRQ_MS_PER_S),
    HOLD_W'(`BTIRQ_HOLD8_S * `BTIRQ_MS_PER_S)
  };
  localparam logic [HOLD_W-1:0] HOLD_MAX = HOLD_MS[NH-1];

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PRE_W-1:0]      pre_reg;
  logic                  tick_reg;
  logic                  pressed;
  logic                  press_pulse;
  logic                  release_pulse;
  logic [HOLD_W-1:0]     hold_ms_reg;
  logic [NH-1:0]         hold_level_reg;
  logic [NH-1:0]         hold_event_reg;
  btirq_pkg::btirq_byte_t tstat_reg;
  btirq_pkg::btirq_byte_t tstat_next;
  btirq_pkg::btirq_byte_t tmask_reg;
  btirq_pkg::btirq_byte_t tsense_reg;
  btirq_pkg::btirq_byte_t tsense_next;
  btirq_pkg::btirq_byte_t bstat_reg;
  btirq_pkg::btirq_byte_t bstat_next;
  btirq_pkg::btirq_byte_t bmask_reg;
  btirq_pkg::btirq_byte_t bsense;
  btirq_pkg::btirq_byte_t bset;
  btirq_pkg::btirq_byte_t tclr;
  btirq_pkg::btirq_byte_t bclr;
  btirq_pkg::btirq_byte_t rd_value;

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  // One shared prescaler keeps the debounce and hold timers narrow
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (pre_reg == PRE_LAST) begin
      pre_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      pre_reg  <= pre_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Button debounce
  // ----------------------------------------------------------------
  btirq_debounce #(
    .LIM_W (DBNC_W)
  ) u_debounce (
    .i_core_clk      (i_core_clk),
    .i_rst           (i_rst),
    .i_tick          (tick_reg),
    .i_button_n      (i_power_button_n),
    .i_fall_ms       (i_dbnc_fall_ms),
    .i_rise_ms       (i_dbnc_rise_ms),
    .o_pressed       (pressed),
    .o_press_pulse   (press_pulse),
    .o_release_pulse (release_pulse)
  );

  // ----------------------------------------------------------------
  // Hold timers
  // ----------------------------------------------------------------
  // Held at zero while released; saturates so it never wraps
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_ms_reg <= '0;
    end else if (!pressed) begin
      hold_ms_reg <= '0;
    end else if (tick_reg && (hold_ms_reg < HOLD_MAX)) begin
      hold_ms_reg <= hold_ms_reg + 1'b1;
    end
  end

  // One level and one event per hold duration
  for (genvar k = 0; k < NH; k++) begin : g_hold
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        hold_level_reg[k] <= 1'b0;
        hold_event_reg[k] <= 1'b0;
      end else if (!pressed) begin
        hold_level_reg[k] <= 1'b0;
        hold_event_reg[k] <= 1'b0;
      end else if (!hold_level_reg[k] && (hold_ms_reg >= HOLD_MS[k])) begin
        hold_level_reg[k] <= 1'b1;
        hold_event_reg[k] <= 1'b1;
      end else begin
        hold_event_reg[k] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Thermal sense and status
  // ----------------------------------------------------------------
  // Sense mirrors comparators; any change of a level is an event
  always_comb begin
    tsense_next = `BTIRQ_SENSE_RST;
    tsense_next[`BTIRQ_THERM_LOW_BIT]  = i_therm_low_level;
    tsense_next[`BTIRQ_THERM_HIGH_BIT] = i_therm_high_level;
  end

  always_comb begin
    tclr = '0;
    if (i_reg_rd && (i_reg_addr == `BTIRQ_ADDR_TSTAT)) begin
      tclr = 8'hFF;
    end else if (i_reg_wr && (i_reg_addr == `BTIRQ_ADDR_TSTAT)) begin
      tclr = i_reg_wdata;
    end
    // Set wins over a clear in the same cycle
    tstat_next = ((tstat_reg & ~tclr) | (tsense_next ^ tsense_reg))
                 & `BTIRQ_THERM_VALID;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tsense_reg <= `BTIRQ_SENSE_RST;
      tstat_reg  <= `BTIRQ_STAT_RST;
    end else begin
      tsense_reg <= tsense_next;
      tstat_reg  <= tstat_next;
    end
  end

  // ----------------------------------------------------------------
  // Button status
  // ----------------------------------------------------------------
  always_comb begin
    bset = '0;
    bset[`BTIRQ_PUSH_BIT] = press_pulse | release_pulse;
    bset[`BTIRQ_HOLD_BASE_BIT +: NH] = hold_event_reg;
    bclr = '0;
    if (i_reg_rd && (i_reg_addr == `BTIRQ_ADDR_BSTAT)) begin
      bclr = 8'hFF;
    end else if (i_reg_wr && (i_reg_addr == `BTIRQ_ADDR_BSTAT)) begin
      bclr = i_reg_wdata;
    end
    bstat_next = ((bstat_reg & ~bclr) | bset) & `BTIRQ_BTN_VALID;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bstat_reg <= `BTIRQ_STAT_RST;
    end else begin
      bstat_reg <= bstat_next;
    end
  end

  // Sense view comes from the debounced state, never the raw pin
  always_comb begin
    bsense = '0;
    bsense[`BTIRQ_PUSH_BIT] = pressed;
    // Gated by the pressed state so no hold level outlives the push bit
    bsense[`BTIRQ_HOLD_BASE_BIT +: NH] = hold_level_reg & {NH{pressed}};
  end

  // ----------------------------------------------------------------
  // Masks
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tmask_reg <= `BTIRQ_TMASK_RST;
      bmask_reg <= `BTIRQ_BMASK_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `BTIRQ_ADDR_TMASK) begin
        tmask_reg <= i_reg_wdata & `BTIRQ_THERM_VALID;
      end
      if (i_reg_addr == `BTIRQ_ADDR_BMASK) begin
        bmask_reg <= i_reg_wdata & `BTIRQ_BTN_VALID;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  // Registered so the pin is glitch-free; one cycle behind status
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_out_n <= 1'b1;
    end else begin
      o_irq_out_n <= ~(|(tstat_reg & ~tmask_reg) |
                       |(bstat_reg & ~bmask_reg));
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero
  always_comb begin
    case (i_reg_addr)
      `BTIRQ_ADDR_TSTAT:  rd_value = tstat_reg;
      `BTIRQ_ADDR_TMASK:  rd_value = tmask_reg;
      `BTIRQ_ADDR_TSENSE: rd_value = tsense_reg;
      `BTIRQ_ADDR_BSTAT:  rd_value = bstat_reg;
      `BTIRQ_ADDR_BMASK:  rd_value = bmask_reg;
      `BTIRQ_ADDR_BSENSE: rd_value = bsense;
      default:            rd_value = 8'h00;
    endcase
  end

  // Data returns the value before any read-clear of the same edge
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_therm_low_sense: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_therm_low_level |=> tsense_reg[`BTIRQ_THERM_LOW_BIT])
    else $error("lower thermal sense not set");

  chk_therm_high_sense: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_therm_high_level |=> !tsense_reg[`BTIRQ_THERM_HIGH_BIT] &&
                            !tsense_reg[1])
    else $error("upper thermal sense or unused bit wrong");

  chk_push_on_press: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(pressed) |=> bstat_reg[`BTIRQ_PUSH_BIT])
    else $error("push status missing after press");

  chk_push_on_release: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(pressed) |=> bstat_reg[`BTIRQ_PUSH_BIT])
    else $error("push status missing after release");

  chk_hold1_timing: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(hold_level_reg[0]) |->
      $past(hold_ms_reg) == HOLD_MS[0] ##1 bstat_reg[1])
    else $error("one second hold event wrong");

  chk_hold8_status: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    hold_event_reg[4] |=> bstat_reg[5] && !bstat_reg[6] && !bstat_reg[7])
    else $error("eight second hold status wrong");

  chk_status_sticky: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    bstat_reg[2] && !(i_reg_addr == `BTIRQ_ADDR_BSTAT &&
                      (i_reg_rd || (i_reg_wr && i_reg_wdata[2])))
    |=> bstat_reg[2])
    else $error("button status lost without clear");

  chk_irq_asserted: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (|(bstat_reg & ~bmask_reg)) |=> !o_irq_out_n)
    else $error("interrupt pin not pulled low");

  chk_irq_masked: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ((tstat_reg & ~tmask_reg) == 8'h00) &&
    ((bstat_reg & ~bmask_reg) == 8'h00) |=> o_irq_out_n)
    else $error("interrupt pin low while masked");

  chk_hold_clear: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(pressed) |=> hold_level_reg == '0 && hold_ms_reg == '0)
    else $error("hold sense not cleared on release");

  chk_therm_event: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $changed(tsense_reg[`BTIRQ_THERM_LOW_BIT]) |->
      tstat_reg[`BTIRQ_THERM_LOW_BIT])
    else $error("thermal crossing not recorded");

  chk_hold_restart: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    hold_event_reg[0] |=> !hold_event_reg[0] [*8])
    else $error("hold event repeated within press");

endmodule

// ---- btirq_button_model.sv ----
// Behavioural model of the power push-button contact.
// Assumes the bench commands press and release at rising clock edges.
`timescale 1ns/10ps

module btirq_button_model #(
  parameter int CHATTER = 3
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_hold,
  output logic      o_power_button_n
);
  logic       hold_reg;
  logic [3:0] chat_reg;

  // ----------------------------------------------------------------
  // Contact
  // ----------------------------------------------------------------
  // Bounce for a few cycles on every change, so the debounce filter
  // always sees chatter; a released contact rests at its pull-up level
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_reg         <= 1'b0;
      chat_reg         <= 4'h0;
      o_power_button_n <= 1'b1;
    end else begin
      hold_reg <= i_hold;
      if (hold_reg != i_hold) begin
        chat_reg         <= 4'(CHATTER);
        o_power_button_n <= ~o_power_button_n;
      end else if (chat_reg != 4'h0) begin
        chat_reg         <= chat_reg - 4'h1;
        o_power_button_n <= ~o_power_button_n;
      end else begin
        o_power_button_n <= ~hold_reg;
      end
    end
  end
endmodule

// ---- btirq_top_bench.sv ----
// Self-checking bench for the button and thermal interrupt logic.
// Assumes btirq_map.svh offsets and a shortened millisecond tick.
`timescale 1ns/10ps
`include "btirq_map.svh"

module btirq_top_bench;
  localparam int MSC = 2;  // Clocks per ms tick, keeps 8 s holds short
  logic       i_core_clk;
  logic       i_rst;
  logic       btn_hold;
  wire logic  power_button_n;
  logic       i_therm_low_level;
  logic       i_therm_high_level;
  logic [7:0] i_dbnc_fall_ms;
  logic [7:0] i_dbnc_rise_ms;
  logic [7:0] i_reg_addr;
  logic       i_reg_wr;
  logic       i_reg_rd;
  logic [7:0] i_reg_wdata;
  logic [7:0] o_reg_rdata;
  logic       o_irq_out_n;
  int         mismatches;
  int         n_compared;
  time        t0;

  btirq_top #(.MS_CYCLES(MSC), .DBNC_W(8)) DUT (
    .i_core_clk        (i_core_clk),
    .i_rst             (i_rst),
    .i_power_button_n  (power_button_n),
    .i_therm_low_level (i_therm_low_level),
    .i_therm_high_level(i_therm_high_level),
    .i_dbnc_fall_ms    (i_dbnc_fall_ms),
    .i_dbnc_rise_ms    (i_dbnc_rise_ms),
    .i_reg_addr        (i_reg_addr),
    .i_reg_wr          (i_reg_wr),
    .i_reg_rd          (i_reg_rd),
    .i_reg_wdata       (i_reg_wdata),
    .o_reg_rdata       (o_reg_rdata),
    .o_irq_out_n       (o_irq_out_n)
  );

  btirq_button_model PRESS (
    .i_core_clk      (i_core_clk),
    .i_rst           (i_rst),
    .i_hold          (btn_hold),
    .o_power_button_n(power_button_n)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clock of 50 ns
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic conclude();
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // Waits until n clocks have passed since t0
  task automatic wait_until(input int n);
    while (($time - t0) / 50 < n) @(posedge i_core_clk);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask

  // Read data is registered at the edge that takes the strobe; it is
  // taken mid-cycle and the task returns on a rising edge
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_core_clk);
    d = o_reg_rdata;
    @(posedge i_core_clk);
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_read(a, d);
    check_byte(d, e);
  endtask

  // Polls button sense until bit 0 equals v, bounded
  task automatic poll_press(input logic v, output logic [7:0] d);
    for (int i = 0; i < 60; i++) begin
      reg_read(`BTIRQ_ADDR_BSENSE, d);
      if (d[0] === v) break;
    end
  endtask

  task automatic pin_after(input logic e);
    wait_cyc(1);
    @(negedge i_core_clk);
    check_pin(o_irq_out_n, e);
    @(posedge i_core_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check_pin(o_irq_out_n, 1'b1);
    expect_reg(`BTIRQ_ADDR_TSTAT, 8'h00);
    expect_reg(`BTIRQ_ADDR_TMASK, 8'h05);
    expect_reg(`BTIRQ_ADDR_TSENSE, 8'h00);
    expect_reg(`BTIRQ_ADDR_BSTAT, 8'h00);
    expect_reg(`BTIRQ_ADDR_BMASK, 8'h3F);
    expect_reg(`BTIRQ_ADDR_BSENSE, 8'h00);
    expect_reg(8'h30, 8'h00);
  endtask

  task automatic test_masks();
    reg_write(`BTIRQ_ADDR_BMASK, 8'hFF);
    expect_reg(`BTIRQ_ADDR_BMASK, 8'h3F);
    reg_write(`BTIRQ_ADDR_BMASK, 8'h15);
    expect_reg(`BTIRQ_ADDR_BMASK, 8'h15);
    reg_write(`BTIRQ_ADDR_BMASK, 8'h3F);
    reg_write(`BTIRQ_ADDR_TSENSE, 8'hFF);
    expect_reg(`BTIRQ_ADDR_TSENSE, 8'h00);
  endtask

  task automatic test_thermal();
    i_therm_low_level <= 1'b1;
    wait_cyc(2);
    expect_reg(`BTIRQ_ADDR_TSENSE, 8'h01);
    i_therm_high_level <= 1'b1;
    wait_cyc(2);
    expect_reg(`BTIRQ_ADDR_TSENSE, 8'h05);
    expect_reg(`BTIRQ_ADDR_TSTAT, 8'h05);
    expect_reg(`BTIRQ_ADDR_TSTAT, 8'h00);
    i_therm_low_level  <= 1'b0;
    i_therm_high_level <= 1'b0;
    wait_cyc(2);
    expect_reg(`BTIRQ_ADDR_TSENSE, 8'h00);
    pin_after(1'b1);
    reg_write(`BTIRQ_ADDR_TMASK, 8'h00);
    pin_after(1'b0);
    reg_write(`BTIRQ_ADDR_TSTAT, 8'h01);
    expect_reg(`BTIRQ_ADDR_TSTAT, 8'h04);
    pin_after(1'b1);
    reg_write(`BTIRQ_ADDR_TMASK, 8'hFF);
    expect_reg(`BTIRQ_ADDR_TMASK, 8'h05);
  endtask

  // A press shorter than the falling debounce leaves no trace
  task automatic test_glitch();
    btn_hold <= 1'b1;
    wait_cyc(4);
    btn_hold <= 1'b0;
    wait_cyc(40);
    expect_reg(`BTIRQ_ADDR_BSTAT, 8'h00);
    expect_reg(`BTIRQ_ADDR_BSENSE, 8'h00);
  endtask

  task automatic test_hold();
    int         hold_s [5] = '{1, 2, 3, 4, 8};
    logic [7:0] lvl;
    logic [7:0] d;
    lvl = 8'h01;
    btn_hold <= 1'b1;
    poll_press(1'b1, d);
    t0 = $time;
    check_byte(d, 8'h01);
    reg_write(`BTIRQ_ADDR_BMASK, 8'h3E);
    pin_after(1'b0);
    reg_write(`BTIRQ_ADDR_BMASK, 8'h3F);
    pin_after(1'b1);
    expect_reg(`BTIRQ_ADDR_BSTAT, 8'h01);
    expect_reg(`BTIRQ_ADDR_BSTAT, 8'h00);
    // Margin of 8 clocks covers tick jitter and read latency
    for (int k = 0; k < 5; k++) begin
      wait_until(hold_s[k] * 1000 * MSC - 8);
      expect_reg(`BTIRQ_ADDR_BSENSE, lvl);
      wait_until(hold_s[k] * 1000 * MSC + 8);
      lvl = lvl | (8'h02 << k);
      expect_reg(`BTIRQ_ADDR_BSENSE, lvl);
      expect_reg(`BTIRQ_ADDR_BSTAT, 8'h02 << k);
    end
    btn_hold <= 1'b0;
    poll_press(1'b0, d);
    check_byte(d, 8'h00);
    expect_reg(`BTIRQ_ADDR_BSTAT, 8'h01);
  endtask

  // A second press starts its hold timing afresh
  task automatic test_restart();
    logic [7:0] d;
    btn_hold <= 1'b1;
    poll_press(1'b1, d);
    t0 = $time;
    wait_until(1000 * MSC - 8);
    expect_reg(`BTIRQ_ADDR_BSENSE, 8'h01);
    wait_until(1000 * MSC + 8);
    expect_reg(`BTIRQ_ADDR_BSENSE, 8'h03);
    btn_hold <= 1'b0;
    poll_press(1'b0, d);
  endtask

  // Status holds push and one-second bits here; write-1 drops only one
  task automatic test_rerst();
    reg_write(`BTIRQ_ADDR_BSTAT, 8'h02);
    reg_write(`BTIRQ_ADDR_BMASK, 8'h3D);
    pin_after(1'b1);
    reg_write(`BTIRQ_ADDR_BMASK, 8'h00);
    pin_after(1'b0);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    wait_cyc(2);
    i_rst <= 1'b0;
    check_pin(o_irq_out_n, 1'b1);
    expect_reg(`BTIRQ_ADDR_BMASK, 8'h3F);
    expect_reg(`BTIRQ_ADDR_BSTAT, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mismatches         = 0;
    n_compared         = 0;
    t0                 = 0;
    i_rst              = 1'b1;
    btn_hold           = 1'b0;
    i_therm_low_level  = 1'b0;
    i_therm_high_level = 1'b0;
    i_dbnc_fall_ms     = 8'h03;
    i_dbnc_rise_ms     = 8'h02;
    i_reg_addr         = 8'h00;
    i_reg_wr           = 1'b0;
    i_reg_rd           = 1'b0;
    i_reg_wdata        = 8'h00;
    wait_cyc(2);
    i_rst <= 1'b0;
    test_reset();
    test_masks();
    test_thermal();
    test_glitch();
    test_hold();
    test_restart();
    test_rerst();
    conclude();
  end

  // Run needs about 18000 clocks; over three times that means a hang
  initial begin
    repeat (60000) @(posedge i_core_clk);
    mismatches++;
    conclude();
  end
endmodule
